// File: dcpa_arbiter.sv
// Private bus arbiter shared by a primary and a dual processor
// What this block and its system must do
// [RULE_01] Only the bus owner starts cycles
// [RULE_02] Waiting cpu requests the bus privately
// [RULE_03] Grant waits unless pipelining is allowed
// [RULE_04] Grant on idle bus transfers ownership immediately
// [RULE_05] Next-address low allows pipeline or handover
// [RULE_06] Cache attributes sampled at next-address or ready
// [RULE_07] At most two cycles outstanding
// [RULE_08] No cross-cpu write behind write
// [RULE_09] Cross-cpu io ok except write into write
// [RULE_10] Same-cpu io pipelining only for string io
// [RULE_11] Flush invalidates, modified lines written back
// [RULE_12] Dual takes bus, flushes first, no ack
// [RULE_13] Dual hands bus to primary when clean
// [RULE_14] Primary drains, flushes, issues ack, keeps bus
// [RULE_15] Dual halts until flush ack seen
// [RULE_16] Exactly one ack after both flushes
// [RULE_17] System holds flush off until ack done
// [RULE_18] System drops flush before ack ready
// [RULE_19] Writeback-invalidate flushes executing cpu only
// [RULE_20] Back-off floats buses and aborts cycles
// [RULE_21] Ownership may change while backed off
// [RULE_22] System keeps cacheability on reruns
// [RULE_23] No new cycles after hold two clocks; the flush ack cycle is not blocked by hold
// [RULE_24] Primary owns bus after reset
module dcpa_arbiter
  import dcpa_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  input  wire logic [1:0] CYC_REQ,
  input  wire logic [3:0] CYC_KIND,
  input  wire logic [1:0] CYC_IO,
  input  wire logic [1:0] STRING_IO_ACTIVE,
  input  wire logic       NEXT_ADDRESS_N,
  input  wire logic       BURST_DATA_READY_N,
  input  wire logic       CYCLE_LAST_READY,
  input  wire logic       CACHEABLE_N,
  input  wire logic       WRITE_POLICY_SEL,
  input  wire logic       BUS_BACKOFF_N,
  input  wire logic       HOLD,
  input  wire logic       FLUSH_N,
  input  wire logic [1:0] WRITEBACK_INVALIDATE_INSTR_REQ,
  input  wire logic [1:0] CACHE_CLEAN,
  output logic [1:0]      CYC_START,
  output logic            BUS_OWNER_CPU,
  output logic            PRIVATE_BUS_REQUEST_N,
  output logic            PRIVATE_BUS_GRANT_N,
  output logic            BUS_FLOAT_N,
  output logic [1:0]      CACHE_FLUSH_GO,
  output logic            FLUSH_ACK_START,
  output logic            DUAL_HALT,
  output logic            ATTR_CACHEABLE_N,
  output logic            ATTR_WRITE_POLICY
);
  import dcpa_pkg::*;

  logic       owner_q, owner_d;
  logic       preq_n_q, preq_n_d;
  logic       pgnt_n_q, pgnt_n_d;
  logic       float_n_q, float_n_d;
  logic [1:0] start_q, start_d;
  logic [1:0] go_q, go_d;
  logic       ack_q, ack_d;
  logic       halt_q, halt_d;
  logic       ken_q, ken_d;
  logic       wbwt_q, wbwt_d;
  logic       attr_done_q, attr_done_d;
  logic [1:0] hold_cnt_q, hold_cnt_d;
  dcpa_flush_type fl_q, fl_d;

  logic       waiting;
  logic       bus_backoff_n;
  logic       hold_block;
  logic       cyc_done;
  logic [1:0] out_cnt;
  logic       head_cpu;
  logic [1:0] head_kind;
  logic       head_io;
  logic       pipe_ok;
  logic       issue;
  logic       issue_cpu;
  logic [1:0] want;

  assign waiting = ~owner_q;
  assign bus_backoff_n = ~BUS_BACKOFF_N;
  assign cyc_done = ~BURST_DATA_READY_N & CYCLE_LAST_READY;
  // Hold blocks starts only once two clocks old
  assign hold_block = (hold_cnt_q >= HOLD_BLOCK_CK); // [RULE_23]

  dcpa_cyc_track u_track (
    .clk        (REF_CLK),
    .rst_n      (RESET_N),
    .start      (issue),
    .start_cpu  (issue_cpu),
    .start_kind (CYC_KIND[issue_cpu*2 +: 2]),
    .start_io   (CYC_IO[issue_cpu]),
    .done       (cyc_done),
    .abort      (bus_backoff_n), // [RULE_20]
    .count      (out_cnt),
    .head_cpu   (head_cpu),
    .head_kind  (head_kind),
    .head_io    (head_io)
  );

  // Requests are masked during flush: the dual halts, primary waits
  always_comb begin
    want = CYC_REQ;
    if (halt_q) begin
      want[CPU_DUAL] = 1'b0; // [RULE_15]
    end
    if (fl_q != DCPA_FL_IDLE) begin
      want[CPU_PRIMARY] = 1'b0;
    end
  end

  // Pipelining legality for a cycle from cpu c behind the head cycle
  function automatic logic can_pipe(input logic c);
    logic same;
    logic io_n;
    logic wr_n;
    same = (c == head_cpu);
    io_n = CYC_IO[c];
    wr_n = (CYC_KIND[c*2 +: 2] == CYC_WRITE);
    can_pipe = 1'b1;
    if (head_kind == CYC_WBACK || CYC_KIND[c*2 +: 2] == CYC_WBACK) begin
      can_pipe = 1'b0;
    end else if (!same && head_kind == CYC_WRITE && wr_n) begin
      can_pipe = 1'b0; // [RULE_08] [RULE_09]
    end else if (same && (head_io || io_n) && !STRING_IO_ACTIVE[c]) begin
      can_pipe = 1'b0; // [RULE_10]
    end
    return can_pipe;
  endfunction

  // Owner issues: idle bus, or one pipelined slot on next-address
  always_comb begin
    issue_cpu = owner_q;
    pipe_ok = can_pipe(owner_q);
    issue = want[owner_q] & preq_n_q // Waiting request first [RULE_03]
          & ~bus_backoff_n & ~hold_block & float_n_q // [RULE_01]
          & ((out_cnt == 2'h0)
          | (out_cnt == 2'h1 & ~NEXT_ADDRESS_N & pipe_ok)); // [RULE_05]
    if (out_cnt >= MAX_OUTSTAND) begin
      issue = 1'b0; // [RULE_07]
    end
  end

  // Ownership, private request and grant [RULE_02] [RULE_12]
  always_comb begin
    logic handover;
    handover = 1'b0;
    owner_d  = owner_q;
    preq_n_d = ~(want[waiting] | (fl_q == DCPA_FL_DUAL_REQ && waiting));
    pgnt_n_d = 1'b1;
    if (fl_q == DCPA_FL_HANDOFF) begin
      handover = (owner_q == CPU_DUAL); // [RULE_13]
    end else if (!preq_n_q && !issue && !(fl_q == DCPA_FL_ACK_CYCLE)) begin
      // Grant on idle bus or under next-address [RULE_03] [RULE_05]
      handover = (out_cnt == 2'h0)
               | (out_cnt == 2'h1 & ~NEXT_ADDRESS_N & can_pipe(waiting));
    end
    if (bus_backoff_n && !preq_n_q) begin
      handover = 1'b1; // [RULE_21]
    end
    if (handover) begin
      owner_d  = ~owner_q; // [RULE_04]
      pgnt_n_d = 1'b0;
      preq_n_d = 1'b1;
    end
  end

  // Cycle start strobes and bus float
  always_comb begin
    start_d = 2'h0;
    if (issue) begin
      start_d[issue_cpu] = 1'b1;
    end
    float_n_d = ~bus_backoff_n; // [RULE_20]
  end

  // Cache attribute sampling, first of next-address or ready
  always_comb begin
    ken_d = ken_q;
    wbwt_d = wbwt_q;
    attr_done_d = attr_done_q;
    if (issue) begin
      attr_done_d = 1'b0;
    end
    if (!attr_done_q && out_cnt != 2'h0
        && (!NEXT_ADDRESS_N || !BURST_DATA_READY_N)) begin
      ken_d = CACHEABLE_N; // [RULE_06]
      wbwt_d = WRITE_POLICY_SEL;
      attr_done_d = 1'b1;
    end
  end

  // Hold age counter saturates at the block threshold
  always_comb begin
    hold_cnt_d = 2'h0;
    if (HOLD) begin
      hold_cnt_d = (hold_cnt_q >= HOLD_BLOCK_CK) ? hold_cnt_q
                                                 : hold_cnt_q + 2'h1;
    end
  end

  // Combined flush sequence, dual first then primary with one ack
  always_comb begin
    fl_d = fl_q;
    go_d = WRITEBACK_INVALIDATE_INSTR_REQ; // [RULE_19]
    ack_d = 1'b0;
    halt_d = halt_q;
    unique case (fl_q)
      DCPA_FL_IDLE: begin
        if (!FLUSH_N) begin
          halt_d = 1'b1;
          fl_d = owner_q ? DCPA_FL_DUAL_RUN : DCPA_FL_DUAL_REQ; // [RULE_12]
        end
      end
      DCPA_FL_DUAL_REQ: begin
        if (owner_q == CPU_DUAL && out_cnt == 2'h0) begin
          fl_d = DCPA_FL_DUAL_RUN;
        end
      end
      DCPA_FL_DUAL_RUN: begin
        go_d[CPU_DUAL] = 1'b1; // [RULE_11]
        if (CACHE_CLEAN[CPU_DUAL] && out_cnt == 2'h0) begin
          fl_d = DCPA_FL_HANDOFF;
        end
      end
      DCPA_FL_HANDOFF: begin
        if (owner_q == CPU_PRIMARY) begin
          fl_d = DCPA_FL_PRIM_DRAIN;
        end
      end
      DCPA_FL_PRIM_DRAIN: begin
        if (out_cnt == 2'h0) begin
          fl_d = DCPA_FL_PRIM_RUN; // [RULE_14]
        end
      end
      DCPA_FL_PRIM_RUN: begin
        go_d[CPU_PRIMARY] = 1'b1; // [RULE_11]
        if (CACHE_CLEAN[CPU_PRIMARY] && out_cnt == 2'h0 && !bus_backoff_n) begin
          ack_d = 1'b1; // [RULE_16]
          fl_d = DCPA_FL_ACK_CYCLE;
        end
      end
      DCPA_FL_ACK_CYCLE: begin
        if (cyc_done) begin
          halt_d = 1'b0; // [RULE_15]
          fl_d = DCPA_FL_ACK_WAIT;
        end
      end
      DCPA_FL_ACK_WAIT: begin
        // Relies on the system releasing flush first [RULE_17] [RULE_18]
        if (FLUSH_N) begin
          fl_d = DCPA_FL_IDLE;
        end
      end
    endcase
  end

  // All state registers; reset leaves the primary as owner
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      owner_q     <= CPU_PRIMARY; // [RULE_24]
      preq_n_q    <= 1'b1;
      pgnt_n_q    <= 1'b1;
      float_n_q   <= 1'b1;
      start_q     <= 2'h0;
      go_q        <= 2'h0;
      ack_q       <= 1'b0;
      halt_q      <= 1'b0;
      ken_q       <= 1'b1;
      wbwt_q      <= 1'b0;
      attr_done_q <= 1'b1;
      hold_cnt_q  <= 2'h0;
      fl_q        <= DCPA_FL_IDLE;
    end else begin
      owner_q     <= owner_d;
      preq_n_q    <= preq_n_d;
      pgnt_n_q    <= pgnt_n_d;
      float_n_q   <= float_n_d;
      start_q     <= start_d;
      go_q        <= go_d;
      ack_q       <= ack_d;
      halt_q      <= halt_d;
      ken_q       <= ken_d;
      wbwt_q      <= wbwt_d;
      attr_done_q <= attr_done_d;
      hold_cnt_q  <= hold_cnt_d;
      fl_q        <= fl_d;
    end
  end

  assign CYC_START             = start_q;
  assign BUS_OWNER_CPU         = owner_q;
  assign PRIVATE_BUS_REQUEST_N = preq_n_q;
  assign PRIVATE_BUS_GRANT_N   = pgnt_n_q;
  assign BUS_FLOAT_N           = float_n_q;
  assign CACHE_FLUSH_GO        = go_q;
  assign FLUSH_ACK_START       = ack_q;
  assign DUAL_HALT             = halt_q;
  assign ATTR_CACHEABLE_N      = ken_q;
  assign ATTR_WRITE_POLICY     = wbwt_q;

  // Assertions share the bus clock; reset disables them
  default clocking chk_cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  chk_start_owner_only: assert property ( // [RULE_01]
    CYC_START != 2'h0 |-> CYC_START == (BUS_OWNER_CPU ? 2'h2 : 2'h1))
    else $error("cycle started by non-owner");
  chk_backoff_float: assert property ( // [RULE_20]
    bus_backoff_n |=> !BUS_FLOAT_N && CYC_START == 2'h0)
    else $error("bus not floated after backoff");
  chk_outstanding_max: assert property ( // [RULE_07]
    out_cnt <= MAX_OUTSTAND)
    else $error("more than two cycles outstanding");
  chk_hold_blocks_start: assert property ( // [RULE_23]
    HOLD ##1 HOLD ##1 HOLD |=> CYC_START == 2'h0)
    else $error("cycle started under aged hold");
  chk_grant_flips_owner: assert property ( // [RULE_04]
    $fell(PRIVATE_BUS_GRANT_N) |-> BUS_OWNER_CPU != $past(BUS_OWNER_CPU))
    else $error("grant without ownership change");
  chk_ack_after_clean: assert property ( // [RULE_16]
    $rose(FLUSH_ACK_START) |->
      $past(CACHE_CLEAN[CPU_PRIMARY]) && BUS_OWNER_CPU == CPU_PRIMARY)
    else $error("flush ack before primary clean");
  chk_dual_halted: assert property ( // [RULE_15]
    DUAL_HALT |=> !CYC_START[CPU_DUAL])
    else $error("dual started cycle while halted");
  chk_ack_single: assert property ( // [RULE_16]
    FLUSH_ACK_START |=> !FLUSH_ACK_START)
    else $error("flush ack longer than one cycle");
endmodule

// File: dcpa_pkg.sv
// Package for the dual processor private bus arbiter
package dcpa_pkg;
  localparam logic       CPU_PRIMARY   = 1'h0;
  localparam logic       CPU_DUAL      = 1'h1;
  localparam logic [1:0] MAX_OUTSTAND  = 2'h2;
  localparam logic [1:0] HOLD_BLOCK_CK = 2'h2;
  localparam logic [1:0] CYC_NONE      = 2'h0;
  localparam logic [1:0] CYC_READ      = 2'h1;
  localparam logic [1:0] CYC_WRITE     = 2'h2;
  localparam logic [1:0] CYC_WBACK     = 2'h3;

  typedef enum logic [2:0] {
    DCPA_FL_IDLE,
    DCPA_FL_DUAL_REQ,
    DCPA_FL_DUAL_RUN,
    DCPA_FL_HANDOFF,
    DCPA_FL_PRIM_DRAIN,
    DCPA_FL_PRIM_RUN,
    DCPA_FL_ACK_CYCLE,
    DCPA_FL_ACK_WAIT
  } dcpa_flush_type;
endpackage

// File: dcpa_cyc_track.sv
// Outstanding bus cycle tracker, two entries of cycle attributes
module dcpa_cyc_track
  import dcpa_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       start_cpu,
  input  wire logic [1:0] start_kind,
  input  wire logic       start_io,
  input  wire logic       done,
  input  wire logic       abort,
  output logic [1:0]      count,
  output logic            head_cpu,
  output logic [1:0]      head_kind,
  output logic            head_io
);
  logic [1:0] cnt_q, cnt_d;
  logic [3:0] ent_q [2];
  logic [3:0] ent_d [2];

  // Entry 0 is the active cycle; a retire shifts entry 1 down
  always_comb begin
    cnt_d = cnt_q;
    ent_d = ent_q;
    if (abort) begin
      cnt_d = CYC_NONE;
    end else begin
      if (done && cnt_q != 2'h0) begin
        ent_d[0] = ent_q[1];
        cnt_d = cnt_q - 2'h1;
      end
      if (start && cnt_d < MAX_OUTSTAND) begin
        ent_d[cnt_d[0]] = {start_cpu, start_kind, start_io};
        cnt_d = cnt_d + 2'h1;
      end
    end
  end

  // Register stage for the tracker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 2'h0;
      ent_q[0] <= 4'h0;
      ent_q[1] <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      ent_q <= ent_d;
    end
  end

  assign count     = cnt_q;
  assign head_cpu  = ent_q[cnt_q == 2'h2 ? 1 : 0][3];
  assign head_kind = ent_q[cnt_q == 2'h2 ? 1 : 0][2:1];
  assign head_io   = ent_q[cnt_q == 2'h2 ? 1 : 0][0];
endmodule

// File: dcpa_sys_model.sv
// Chipset and cache model on the far side of the arbiter
module dcpa_sys_model #(
  parameter int LAT = 3
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] cyc_start,
  input  wire logic       ack_start,
  input  wire logic [1:0] flush_go,
  input  wire logic       bus_backoff_n_n,
  input  wire logic       flush_req,
  input  wire logic       pipe_en,
  output logic            next_address_n,
  output logic            ready_n,
  output logic            last_ready,
  output logic [1:0]      cache_clean,
  output logic            flush_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int   pend;
  int   tmr;
  int   cln0;
  int   cln1;
  logic off_q;

  // One retire every LAT clocks; back-off throws pending cycles away
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend = 0;
      tmr = 0;
      ready_n <= 1'b1;
      last_ready <= 1'b0;
      next_address_n <= 1'b1;
    end else begin
      ready_n <= 1'b1;
      last_ready <= 1'b0;
      if (!bus_backoff_n_n) pend = 0;
      tmr = (pend > 0) ? tmr + 1 : 0;
      if (pend > 0 && tmr >= LAT) begin
        ready_n <= 1'b0;
        last_ready <= 1'b1;
        pend--;
        tmr = 0;
      end
      // A start seen with back-off was aborted with the rest
      if (bus_backoff_n_n && (|cyc_start || ack_start)) pend++;
      next_address_n <= !(pipe_en && pend == 1); // Pipelining offered
    end
  end

  // Caches turn clean a few clocks after a flush command
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cln0 = 0;
      cln1 = 0;
      cache_clean <= 2'h0;
      off_q <= 1'b0;
      flush_n <= 1'b1;
    end else begin
      cln0 = flush_go[0] ? cln0 + 1 : 0;
      cln1 = flush_go[1] ? cln1 + 1 : 0;
      cache_clean <= {cln1 > 3, cln0 > 3};
      // Dropped well before the ack cycle's ready
      if (ack_start) off_q <= 1'b1;
      else if (!flush_req) off_q <= 1'b0; // No re-raise early
      flush_n <= !(flush_req && !off_q && !ack_start);
    end
  end
endmodule

// File: dcpa_tb.sv
// Self-checking testbench of the private bus arbiter
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcpa_pkg::*;
  logic       clk = 0, rst_n = 0, na_n, rdy_n, last, float_n, ack;
  logic       cach_n = 1, wpol = 0, bus_backoff_n_n = 1, hold = 0, fl_n, halt;
  logic       owner, preq_n, pgnt_n, acach_n, awp, fl_req = 0, pipe = 0;
  logic [1:0] req = 0, io = 0, sio = 0, writeback_invalidate_instr = 0, clean, start, go;
  logic [3:0] kind = 0;
  int         error_cnt = 0, checks = 0, outst = 0, acks = 0, xpipe = 0;
  logic [1:0] cpus = 0, pkind;
  logic       pcpu, xw;

  dcpa_arbiter dut (.REF_CLK(clk), .RESET_N(rst_n), .CYC_REQ(req),
    .CYC_KIND(kind), .CYC_IO(io), .STRING_IO_ACTIVE(sio),
    .NEXT_ADDRESS_N(na_n), .BURST_DATA_READY_N(rdy_n),
    .CYCLE_LAST_READY(last), .CACHEABLE_N(cach_n),
    .WRITE_POLICY_SEL(wpol), .BUS_BACKOFF_N(bus_backoff_n_n), .HOLD(hold),
    .FLUSH_N(fl_n), .WRITEBACK_INVALIDATE_INSTR_REQ(writeback_invalidate_instr), .CACHE_CLEAN(clean),
    .CYC_START(start), .BUS_OWNER_CPU(owner),
    .PRIVATE_BUS_REQUEST_N(preq_n), .PRIVATE_BUS_GRANT_N(pgnt_n),
    .BUS_FLOAT_N(float_n), .CACHE_FLUSH_GO(go), .FLUSH_ACK_START(ack),
    .DUAL_HALT(halt), .ATTR_CACHEABLE_N(acach_n),
    .ATTR_WRITE_POLICY(awp));
  dcpa_sys_model sys (.clk(clk), .rst_n(rst_n), .cyc_start(start),
    .ack_start(ack), .flush_go(go), .bus_backoff_n_n(bus_backoff_n_n), .flush_req(fl_req),
    .pipe_en(pipe), .next_address_n(na_n), .ready_n(rdy_n),
    .last_ready(last), .cache_clean(clean), .flush_n(fl_n));

  always #5 clk = ~clk;

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [3:0] seen, input logic [3:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // Outstanding cycles seen on the bus; abort clears them all
  always @(posedge clk) begin
    if (ack) acks++;
    if (!rst_n || !bus_backoff_n_n) outst = 0;
    else begin
      if (!rdy_n && last && outst > 0) outst--;
      if (|start) begin
        cpus |= start;
        xw = outst == 1 && start[1] != pcpu && pkind == CYC_WRITE
          && (start[1] ? kind[3:2] : kind[1:0]) == CYC_WRITE;
        if (outst == 1 && start[1] != pcpu) xpipe++;
        check(4'(xw), 4'h0, "cross write");
        outst++;
        pcpu = start[1];
        pkind = start[1] ? kind[3:2] : kind[1:0];
        check(4'(outst <= 2), 4'h1, "outstanding");
      end
    end
  end

  task automatic t_single();
    int i;
    cach_n = 0;
    wpol = 1;
    kind = 4'h1;
    req = 2'b01;
    for (i = 0; i < 20 && start === 2'b00; i++) step();
    req = 0;
    check(start, 2'b01, "primary start");
    for (i = 0; i < 20 && rdy_n !== 1'b0; i++) step();
    step();
    // Flip the inputs after ready: the sampled attribute must hold
    cach_n = 1;
    wpol = 0;
    step(2);
    check({acach_n, awp}, 2'b01, "attributes");
  endtask

  task automatic t_handover();
    int i;
    kind = 4'h4;
    req = 2'b10;
    for (i = 0; i < 5 && preq_n !== 1'b0; i++) step();
    check(preq_n, 1'b0, "request");
    for (i = 0; i < 20 && pgnt_n !== 1'b0; i++) step();
    check(pgnt_n, 1'b0, "grant");
    for (i = 0; i < 20 && start === 2'b00; i++) step();
    req = 0;
    check({start, owner}, 3'b101, "new owner start");
    step(10);
  endtask

  task automatic t_pipe();
    cpus = 0;
    xpipe = 0;
    pipe = 1;
    kind = 4'hA;
    req = 2'b11;
    step(60);
    kind = 4'h5;
    step(60);
    req = 0;
    pipe = 0;
    step(20);
    check(cpus, 2'b11, "both cpus ran");
    check(4'(xpipe > 0), 4'h1, "cross pipelined");
  endtask

  task automatic t_backoff();
    int i;
    cach_n = 0; // Held through the rerun
    kind = 4'h1;
    req = 2'b01;
    for (i = 0; i < 40 && start === 2'b00; i++) step();
    bus_backoff_n_n = 0;
    step();
    check({float_n, start}, 3'b000, "float on backoff");
    bus_backoff_n_n = 1;
    step();
    check(float_n, 1'b1, "float ends");
    for (i = 0; i < 20 && start === 2'b00; i++) step();
    req = 0;
    check(start, 2'b01, "rerun after backoff");
    for (i = 0; i < 20 && rdy_n !== 1'b0; i++) step();
    step(2);
    check(acach_n, 1'b0, "rerun attribute");
    cach_n = 1;
    step(20);
  endtask

  task automatic t_hold();
    int i;
    int n;
    n = 0;
    hold = 1;
    step(2);
    req = 2'b01;
    for (i = 0; i < 10; i++) begin
      step();
      if (|start) n++;
    end
    check(4'(n), 4'h0, "no start under hold");
    hold = 0;
    for (i = 0; i < 20 && start === 2'b00; i++) step();
    req = 0;
    check(4'(|start), 4'h1, "start after hold");
    step(20);
  endtask

  task automatic t_flush();
    int i;
    acks = 0;
    fl_req = 1;
    for (i = 0; i < 60 && go === 2'b00; i++) step();
    check(go, 2'b10, "dual flushes first");
    for (i = 0; i < 60 && go[0] !== 1'b1; i++) step();
    check({owner, halt}, 2'b01, "primary flush");
    for (i = 0; i < 60 && ack !== 1'b1; i++) step();
    check(owner, 1'b0, "ack owner");
    step(2);
    fl_req = 0;
    step(30);
    check(4'(acks), 4'h1, "single ack");
    check(halt, 1'b0, "dual resumes");
  endtask

  task automatic t_writeback_invalidate_instr();
    int i;
    acks = 0;
    writeback_invalidate_instr = 2'b01;
    for (i = 0; i < 20 && go === 2'b00; i++) step();
    check(go, 2'b01, "own caches only");
    step(8);
    writeback_invalidate_instr = 0;
    step(10);
    check(4'(acks), 4'h0, "no ack");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Scenarios need under a thousand clocks; ten times that means a hang
  initial begin
    #100000;
    error_cnt++;
    results();
  end

  initial begin
    step(2);
    rst_n = 1;
    step();
    check({owner, preq_n, pgnt_n, float_n}, 4'h7, "reset");
    t_single();
    t_handover();
    t_pipe();
    t_backoff();
    t_hold();
    t_flush();
    t_writeback_invalidate_instr();
    results();
  end
endmodule
